/* File: common/incx_dec_if.sv */
// decoded instruction fields between decoder and executor
`timescale 1ns/100ps
interface incx_dec_if;
	import incx_pkg::*;
	incx_op_e   op;
	logic       toFile;
	incx_addr_t addr;
	modport dec (output op, output toFile, output addr);
	modport exe (input op, input toFile, input addr);
endinterface

/* File: common/incx_params.svh */
// constants for the increment instruction executor
`ifndef INCX_PARAMS_SVH
`define INCX_PARAMS_SVH
`define INCX_OPC_INC    6'h0A
`define INCX_OPC_INCSZ  6'h0F
`define INCX_OPC_MSB    11
`define INCX_OPC_LSB    6
`define INCX_DEST_BIT   5
`define INCX_ADDR_MSB   4
`define INCX_DATA_W     8
`define INCX_IDLE_WORD  12'h000
`define INCX_ONE        8'h01
`define INCX_ZERO       8'h00
`endif

/* File: common/incx_pkg.sv */
// types for the increment instruction executor
package incx_pkg;
	typedef logic [11:0] incx_word_t;
	typedef logic [7:0]  incx_data_t;
	typedef logic [4:0]  incx_addr_t;
	typedef enum logic [1:0] {
		INCX_OP_NONE  = 2'b00,
		INCX_OP_INC   = 2'b01,
		INCX_OP_INCSZ = 2'b10
	} incx_op_e;
endpackage

/* File: dv/incx_exec_properties.sv */
// port assertions for the increment executor
`timescale 1ns/100ps
module incx_exec_props (
	input logic clk, rst, instrValid, fileWrEn, wWrEn, zeroWrEn, zeroVal, skipReq, nopSlot, busy,
	input incx_pkg::incx_word_t instrWord,
	input incx_pkg::incx_data_t fileRdData, fileWrData, wWrData,
	input incx_pkg::incx_addr_t fileRdAddr, fileWrAddr
);
	import incx_pkg::*;
	wire tk = instrValid && !busy;
	wire inc = tk && instrWord[11:6] == 6'h0A;
	wire sz = tk && instrWord[11:6] == 6'h0F;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	to_file_a: assert property ((inc || sz) && instrWord[5] |=> fileWrEn && !wWrEn
		&& fileWrData == $past(fileRdData) + 8'h01) else $error("file write");
	to_w_a: assert property ((inc || sz) && !instrWord[5] |=> wWrEn && !fileWrEn
		&& wWrData == $past(fileRdData) + 8'h01) else $error("w write");
	zero_flag_a: assert property (inc |=> zeroWrEn && zeroVal == ($past(fileRdData) == 8'hFF))
		else $error("zero flag");
	skip_flags_a: assert property (sz |=> !zeroWrEn) else $error("flag touched");
	skip_zero_a: assert property (sz |=> skipReq == ($past(fileRdData) == 8'hFF))
		else $error("skip");
	skip_nop_a: assert property (skipReq |-> busy ##1 nopSlot && !fileWrEn && !wWrEn)
		else $error("slot");
	read_addr_a: assert property (fileRdAddr == instrWord[4:0]) else $error("addr");
	write_addr_a: assert property ((inc || sz) |=> fileWrAddr == $past(fileRdAddr))
		else $error("write addr");
	other_word_a: assert property (!(inc || sz) |=> !fileWrEn && !wWrEn && !skipReq)
		else $error("stray");
endmodule
bind incx_exec incx_exec_props incx_exec_props_i (.*);

/* File: dv/incx_exec_tb.sv */
// bench for the increment executor
`timescale 1ns/100ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nFail++; \
	$display("CHECK FAILED %0t output mismatch", $time); end end
module incx_exec_tb;
	import incx_pkg::*;
	logic clk = 0, rst = 1, instrValid = 0, fileWrEn, wWrEn, zeroWrEn, zeroVal, skipReq, nopSlot, busy;
	logic eF, eW, eZ, eV, eS = 0, eN, inc, sz;
	incx_word_t instrWord = 12'h000;
	incx_data_t fileRdData = 8'h00, fileWrData, wWrData, sum;
	incx_addr_t fileRdAddr, fileWrAddr;
	// wrap, skip, word dropped while busy, no skip
	logic [19:0] corner [4] = '{20'h2A5FF, 20'h3E5FF, 20'h28100, 20'h3C07F};
	int seed = 32'h7E2B, nFail = 0, numChecks = 0;
	incx_exec incx_exec_i (.*);
	initial forever #4 clk = ~clk;
	task conclude;
		$display("checks %0d fails %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		for (int i = 0; i < 900; i++) begin
			{instrWord, fileRdData} = i < 4 ? corner[i] : 20'($random(seed));
			if (i > 3 && seed[0]) instrWord[11:6] = seed[1] ? 6'h0A : 6'h0F;
			if (i > 3 && seed[2]) fileRdData = 8'hFF;
			instrValid = i < 4 || seed[5:3] != 0;
			inc = instrValid && !eS && instrWord[11:6] == 6'h0A;
			sz = instrValid && !eS && instrWord[11:6] == 6'h0F;
			sum = fileRdData + 8'h01;
			{eN, eS, eZ, eV} = {eS, sz && !sum, inc, !sum};
			eF = (inc || sz) && instrWord[5];
			eW = (inc || sz) && !instrWord[5];
			#1 `CHK(fileRdAddr, instrWord[4:0])
			@(negedge clk);
			`CHK({fileWrEn, wWrEn, zeroWrEn, skipReq, nopSlot, busy}, {eF, eW, eZ, eS, eN, eS})
			`CHK(eF ? fileWrData : sum, sum)
			`CHK(eF ? fileWrAddr : instrWord[4:0], instrWord[4:0])
			`CHK(eW ? wWrData : sum, sum)
			`CHK(eZ ? zeroVal : eV, eV)
			if (i == 3) $display("corner test done");
		end
		$display("random test done");
		conclude;
	end
endmodule

/* File: logic/incx_decoder.sv */
// opcode decoder for the increment instructions
`timescale 1ns/100ps
`include "incx_params.svh"
module incx_decoder (
	input  wire incx_pkg::incx_word_t instrWord,
	incx_dec_if.dec                   dec
);
	import incx_pkg::*;
	logic [5:0] opField;
	always_comb begin
		opField    = instrWord[`INCX_OPC_MSB:`INCX_OPC_LSB];
		dec.toFile = instrWord[`INCX_DEST_BIT];
		dec.addr   = instrWord[`INCX_ADDR_MSB:0];
		if (opField == `INCX_OPC_INC) begin
			dec.op = INCX_OP_INC;
		end else if (opField == `INCX_OPC_INCSZ) begin
			dec.op = INCX_OP_INCSZ;
		end else begin
			dec.op = INCX_OP_NONE;
		end
	end
endmodule

/* File: logic/incx_exec.sv */
// execution of the increment and increment-skip-on-zero instructions
`timescale 1ns/100ps
`include "incx_params.svh"
module incx_exec (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 instrValid,
	input  wire incx_pkg::incx_word_t instrWord,
	input  wire incx_pkg::incx_data_t fileRdData,
	output incx_pkg::incx_addr_t      fileRdAddr,
	output logic                      fileWrEn,
	output incx_pkg::incx_addr_t      fileWrAddr,
	output incx_pkg::incx_data_t      fileWrData,
	output logic                      wWrEn,
	output incx_pkg::incx_data_t      wWrData,
	output logic                      zeroWrEn,
	output logic                      zeroVal,
	output logic                      skipReq,
	output logic                      nopSlot,
	output logic                      busy
);
	import incx_pkg::*;

	// ----------------------------------------
	// state layout
	// ----------------------------------------
	// one struct holds every flop, so reset and the register stage stay in one place
	typedef struct packed {
		// file register write
		logic       fileWrEn;
		incx_addr_t fileWrAddr;
		incx_data_t fileWrData;
		// working register write
		logic       wWrEn;
		incx_data_t wWrData;
		// status
		logic       zeroWrEn;
		logic       zeroVal;
		// pipeline
		logic       skipReq;
		logic       nopSlot;
		logic       skipPend;
	} incx_state_s;

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	incx_state_s stateReg;
	incx_state_s stateNext;

	// ----------------------------------------
	// decode signals
	// ----------------------------------------
	incx_dec_if decBus ();
	logic       takeWord;
	logic       isInc;
	logic       isIncSkip;
	logic       anyInc;

	// ----------------------------------------
	// incrementer signals
	// ----------------------------------------
	logic [`INCX_DATA_W:0] carry;
	incx_data_t            sum;
	logic                  sumZero;

	// ----------------------------------------
	// decoder
	// ----------------------------------------
	// purely combinational: its fields are valid together with the word
	incx_decoder uDec (
		.instrWord (instrWord),
		.dec       (decBus)
	);

	// ----------------------------------------
	// issue
	// ----------------------------------------
	// the word that arrives while a skip is pending is the one being discarded
	assign takeWord = instrValid && !stateReg.skipPend;

	// ----------------------------------------
	// operation select
	// ----------------------------------------
	// only a word that is taken can start an increment
	always_comb begin
		isInc     = 1'b0;
		isIncSkip = 1'b0;
		unique case (decBus.op)
			INCX_OP_NONE: begin
				isInc     = 1'b0;
				isIncSkip = 1'b0;
			end
			INCX_OP_INC: begin
				isInc     = takeWord;
				isIncSkip = 1'b0;
			end
			INCX_OP_INCSZ: begin
				isInc     = 1'b0;
				isIncSkip = takeWord;
			end
			default: begin
				// spare code of the 2-bit enum: no work rather than a guess
				isInc     = 1'b0;
				isIncSkip = 1'b0;
			end
		endcase
	end

	// both variants share the write-back path
	assign anyInc = isInc || isIncSkip;

	// ----------------------------------------
	// incrementer
	// ----------------------------------------
	// ripple chain: the carry into the lowest cell is the one being added
	assign carry[0] = 1'b1;

	for (genvar b = 0; b < `INCX_DATA_W; b++) begin : gIncBit
		assign sum[b]     = fileRdData[b] ^ carry[b];
		assign carry[b+1] = fileRdData[b] & carry[b];
	end

	// ----------------------------------------
	// zero detect
	// ----------------------------------------
	// carry out of the top cell: operand was all ones, the sum wrapped to zero
	// same answer as comparing the sum with zero, one gate level sooner
	assign sumZero = carry[`INCX_DATA_W];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// file read is combinational: the operand arrives in the same cycle
	always_comb begin
		stateNext = stateReg;

		// strobes are one-cycle pulses
		stateNext.fileWrEn = 1'b0;
		stateNext.wWrEn    = 1'b0;
		stateNext.zeroWrEn = 1'b0;
		stateNext.skipReq  = 1'b0;
		stateNext.nopSlot  = 1'b0;
		stateNext.skipPend = 1'b0;

		// dropped word: this slot runs as a no-op
		if (stateReg.skipPend) begin
			stateNext.nopSlot = 1'b1;
		end

		// write-back; data is held until the next increment
		if (anyInc) begin
			stateNext.fileWrAddr = decBus.addr;
			stateNext.fileWrData = sum;
			stateNext.wWrData    = sum;
			stateNext.fileWrEn   = decBus.toFile;
			stateNext.wWrEn      = !decBus.toFile;
		end

		// zero flag: plain increment only
		if (isInc) begin
			stateNext.zeroWrEn = 1'b1;
			stateNext.zeroVal  = sumZero;
		end

		// skip variant leaves the flags alone
		if (isIncSkip) begin
			stateNext.skipReq  = sumZero;
			stateNext.skipPend = sumZero;
		end
	end

	// ----------------------------------------
	// register stage
	// ----------------------------------------
	// synchronous reset clears every strobe and the pending skip
	always_ff @(posedge clk) begin
		if (rst) begin
			stateReg <= '0;
		end else begin
			stateReg <= stateNext;
		end
	end

	// ----------------------------------------
	// file register port
	// ----------------------------------------
	// read address is not registered: the core answers in the same cycle
	assign fileRdAddr = decBus.addr;
	assign fileWrEn   = stateReg.fileWrEn;
	assign fileWrAddr = stateReg.fileWrAddr;
	assign fileWrData = stateReg.fileWrData;

	// ----------------------------------------
	// working register port
	// ----------------------------------------
	assign wWrEn   = stateReg.wWrEn;
	assign wWrData = stateReg.wWrData;

	// ----------------------------------------
	// status port
	// ----------------------------------------
	assign zeroWrEn = stateReg.zeroWrEn;
	assign zeroVal  = stateReg.zeroVal;

	// ----------------------------------------
	// pipeline control
	// ----------------------------------------
	// busy tells the core that the word now in flight is being thrown away
	assign skipReq = stateReg.skipReq;
	assign nopSlot = stateReg.nopSlot;
	assign busy    = stateReg.skipPend;
endmodule
